/* design/auto_ack_pkg.sv */
// Package for the automatic acknowledgement block: register indices, field
// positions, reset values, the radio-side carrier and the control state type.
// Assumes a 32-bit Wishbone register bus with one register per aligned word.
package auto_ack_pkg;

    // Register indices; the byte address of each is four times its index.
    localparam logic [7:0] IDX_TIMER_LOW = 8'h50;
    localparam logic [7:0] IDX_TIMER_HIGH = 8'h51;
    localparam logic [7:0] IDX_TIMER_CTRL = 8'h52;
    localparam logic [7:0] IDX_FRAME_LOW = 8'h53;
    localparam logic [7:0] IDX_FRAME_HIGH = 8'h54;
    localparam logic [7:0] IDX_AUTO_CTRL = 8'h55;
    localparam logic [7:0] IDX_REPLY_STATUS = 8'h70;

    // Reset values.
    localparam logic [7:0] RST_TIMER_LOW = 8'h08;
    localparam logic [7:0] RST_TIMER_HIGH = 8'h07;
    localparam logic [7:0] RST_TIMER_CTRL = 8'h00;
    localparam logic [7:0] RST_FRAME_LOW = 8'h02;
    localparam logic [7:0] RST_FRAME_HIGH = 8'h00;
    localparam logic [7:0] RST_AUTO_CTRL = 8'h00;

    // Bits of auto_reply_control.
    localparam int BIT_REPLY_STOP = 0;
    localparam int BIT_REPLY_SEND = 1;
    localparam int BIT_AUTO_REPLY = 4;
    localparam int BIT_AUTO_RX = 6;
    localparam int BIT_REPLY_CANCEL = 7;
    // Bit of the timer control register.
    localparam int BIT_TIMER_EN = 0;

    // Frame control field layout, low byte then high byte.
    localparam int FC_TYPE_LSB = 0;
    localparam int FC_TYPE_MSB = 2;
    localparam int FC_SECURITY = 3;
    localparam int FC_PENDING = 4;
    localparam int FC_ACK_REQ = 5;
    localparam int FC_PANID_COMP = 6;
    localparam int FC_DST_MODE_LSB = 10;
    localparam int FC_DST_MODE_MSB = 11;
    localparam int FC_VERSION_LSB = 12;
    localparam int FC_VERSION_MSB = 13;
    localparam int FC_SRC_MODE_LSB = 14;
    localparam int FC_SRC_MODE_MSB = 15;

    // Reply frame: 16 control bits, 8 sequence bits, 16 FCS bits.
    localparam logic [5:0] HDR_BITS = 6'h18;
    localparam logic [5:0] FRAME_BITS = 6'h28;
    localparam logic [15:0] FCS_POLY_REFL = 16'h8408;
    localparam logic [15:0] FCS_INIT = 16'h0000;

    // Status register fields.
    localparam int STS_STATE_LSB = 0;
    localparam int STS_PENDING = 2;
    localparam int STS_AWAIT = 3;
    localparam int STS_SENDING = 4;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_RX_ON,
        ST_TX_ON,
        ST_SENDING
    } radio_state_t;

    // Events from the packet engine, all on clk_i.
    typedef struct packed {
        logic rx_done;
        logic rx_ack_req;
        logic rx_is_ack;
        logic [7:0] rx_seq;
        logic tx_done;
        logic tx_ack_req;
        logic goto_rx;
        logic goto_off;
        logic timer_tick;
    } radio_in_t;

    // Verdict on a received reply frame.
    typedef struct packed {
        logic keep;
        logic drop;
    } ack_verdict_t;

endpackage : auto_ack_pkg

/* design/auto_ack_control.sv */
// Automatic acknowledgement controller: builds and serialises the reply frame,
// tracks the radio state around replies and filters received reply frames.
// Assumes a classic Wishbone master on clk_i and a packet engine on the same
// clock that reports packet events and drains reply bits by valid/ready.
//
// How it works
// [RULE1] Low and high frame control bytes form one field, sent LSB first.
// [RULE2] Field layout: type, security, pending, ack request, PAN compression, modes, version.
// [RULE3] Reply frame is register control, received sequence number, computed FCS.
// [RULE4] With auto reply, an ack-requesting reception prepares the reply in transmit-on.
// [RULE5] With auto receive, sending an ack-requesting packet enters receive-on at once.
// [RULE6] Writing one to the send command transmits the prepared reply.
// [RULE7] Stop command in transmit mode discards the reply; state stays transmit-on.
// [RULE8] Stop command in receive mode halts reception; state becomes transceiver-off.
// [RULE9] Host sets one command at a time; if both, stop wins.
// [RULE10] Host enables address filtering so reply frames can be detected.
// [RULE11] Cancel and auto receive set: accept only the first packet after request.
// [RULE12] Cancel set, auto receive clear: discard every received reply frame.
// [RULE13] Cancel clear: accept every received reply frame.
// [RULE14] Reply frame filtering ignores whether the address matched.
// [RULE15] With auto receive, host waits for status 0x66 before writing.
// [RULE16] With auto reply, host waits for status 0x99 before writing.
// [RULE17] With auto reply, host keeps the transmit alarm level at zero.
// [RULE18] Auto reply with timer enabled sends the reply when the timer expires.
// [RULE19] Send and stop commands are single shots and read back as zero.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps

module auto_ack_control (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Packet engine events
    input wire auto_ack_pkg::radio_in_t radio_i,
    // Reply bit stream
    output logic ack_bit_o,
    output logic ack_valid_o,
    input wire logic ack_ready_i,
    output logic ack_sent_o,
    // Radio state and reply filter verdict
    output auto_ack_pkg::radio_state_t radio_state_o,
    output auto_ack_pkg::ack_verdict_t verdict_o
);

    // Register file.
    logic [7:0] timer_low_q;
    logic [7:0] timer_high_q;
    logic [7:0] timer_ctrl_q;
    logic [7:0] frame_low_q;
    logic [7:0] frame_high_q;
    logic [7:0] auto_ctrl_q;
    logic [31:0] dat_q;
    logic ack_q;

    // Control state.
    auto_ack_pkg::radio_state_t state_q;
    logic pending_q;
    logic await_first_q;
    logic [7:0] seq_q;
    logic [15:0] timer_q;
    logic [23:0] shift_q;
    logic [15:0] fcs_q;
    logic [5:0] count_q;
    logic sent_q;
    auto_ack_pkg::ack_verdict_t verdict_q;

    // Bus decode.
    logic wb_fire;
    logic wr;
    logic cmd_send;
    logic cmd_stop;

    // Settings fields.
    logic auto_reply;
    logic auto_rx;
    logic cancel;
    logic timer_en;

    // Reply start and abort.
    logic start_auto;
    logic start_send;
    logic stop_tx;
    logic stop_rx;

    // Radio events.
    logic capture;
    logic tx_then_rx;

    // Serialiser.
    logic beat;
    logic last_beat;
    logic in_header;
    logic fcs_fb;
    logic [15:0] fcs_shift;

    // True when the addressed word is the given register index.
    function automatic logic hit(input logic [9:0] adr, input logic [7:0] idx);
        hit = (adr[9:2] == idx);
    endfunction : hit

    // Bus: ack rises one cycle after the request and falls the next cycle.
    // Writes land on the edge where the master samples ack high.
    // The wait state lets dat_o leave straight from a flop.
    assign wb_fire = cyc_i & stb_i & ack_q;
    assign wr = wb_fire & we_i & sel_i[0];
    assign ack_o = ack_q;
    assign dat_o = dat_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= cyc_i & stb_i & ~ack_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h0000_0000;
        end else if (cyc_i & stb_i & ~ack_q) begin
            // Unmapped indices read as zero.
            dat_q <= 32'h0000_0000;
            if (hit(adr_i, auto_ack_pkg::IDX_TIMER_LOW)) begin
                dat_q[7:0] <= timer_low_q;
            end else if (hit(adr_i, auto_ack_pkg::IDX_TIMER_HIGH)) begin
                dat_q[7:0] <= timer_high_q;
            end else if (hit(adr_i, auto_ack_pkg::IDX_TIMER_CTRL)) begin
                dat_q[7:0] <= timer_ctrl_q;
            end else if (hit(adr_i, auto_ack_pkg::IDX_FRAME_LOW)) begin
                dat_q[7:0] <= frame_low_q;
            end else if (hit(adr_i, auto_ack_pkg::IDX_FRAME_HIGH)) begin
                dat_q[7:0] <= frame_high_q;
            end else if (hit(adr_i, auto_ack_pkg::IDX_AUTO_CTRL)) begin
                dat_q[7:0] <= auto_ctrl_q;
            end else if (hit(adr_i, auto_ack_pkg::IDX_REPLY_STATUS)) begin
                dat_q[auto_ack_pkg::STS_STATE_LSB +: 2] <= state_q;
                dat_q[auto_ack_pkg::STS_PENDING] <= pending_q;
                dat_q[auto_ack_pkg::STS_AWAIT] <= await_first_q;
                dat_q[auto_ack_pkg::STS_SENDING] <= (state_q == auto_ack_pkg::ST_SENDING);
            end
        end
    end

    // Stored settings. Command bits are never stored, so they read as zero.
    // Reserved bits keep what was written.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_low_q <= auto_ack_pkg::RST_TIMER_LOW;
            timer_high_q <= auto_ack_pkg::RST_TIMER_HIGH;
            timer_ctrl_q <= auto_ack_pkg::RST_TIMER_CTRL;
            frame_low_q <= auto_ack_pkg::RST_FRAME_LOW;
            frame_high_q <= auto_ack_pkg::RST_FRAME_HIGH;
            auto_ctrl_q <= auto_ack_pkg::RST_AUTO_CTRL;
        end else if (wr) begin
            if (hit(adr_i, auto_ack_pkg::IDX_TIMER_LOW)) begin
                timer_low_q <= dat_i[7:0];
            end
            if (hit(adr_i, auto_ack_pkg::IDX_TIMER_HIGH)) begin
                timer_high_q <= dat_i[7:0];
            end
            if (hit(adr_i, auto_ack_pkg::IDX_TIMER_CTRL)) begin
                timer_ctrl_q <= dat_i[7:0];
            end
            if (hit(adr_i, auto_ack_pkg::IDX_FRAME_LOW)) begin
                frame_low_q <= dat_i[7:0]; // [RULE2]
            end
            if (hit(adr_i, auto_ack_pkg::IDX_FRAME_HIGH)) begin
                frame_high_q <= dat_i[7:0]; // [RULE2]
            end
            if (hit(adr_i, auto_ack_pkg::IDX_AUTO_CTRL)) begin
                auto_ctrl_q <= dat_i[7:0] & 8'hFC; // [RULE19]
            end
        end
    end

    // Commands act in the cycle of the write; stop takes priority over send.
    // Without a pending reply send does nothing; stop still halts reception in receive-on.
    assign cmd_stop = wr & hit(adr_i, auto_ack_pkg::IDX_AUTO_CTRL)
                      & dat_i[auto_ack_pkg::BIT_REPLY_STOP]; // [RULE19]
    assign cmd_send = wr & hit(adr_i, auto_ack_pkg::IDX_AUTO_CTRL)
                      & dat_i[auto_ack_pkg::BIT_REPLY_SEND] & ~cmd_stop; // [RULE9]

    assign auto_reply = auto_ctrl_q[auto_ack_pkg::BIT_AUTO_REPLY];
    assign auto_rx = auto_ctrl_q[auto_ack_pkg::BIT_AUTO_RX];
    assign cancel = auto_ctrl_q[auto_ack_pkg::BIT_REPLY_CANCEL];
    assign timer_en = timer_ctrl_q[auto_ack_pkg::BIT_TIMER_EN];

    // An ack-requesting reception while listening prepares a reply.
    assign capture = (state_q == auto_ack_pkg::ST_RX_ON) & radio_i.rx_done
                     & radio_i.rx_ack_req & ~radio_i.rx_is_ack & auto_reply; // [RULE4]
    assign tx_then_rx = radio_i.tx_done & radio_i.tx_ack_req & auto_rx; // [RULE5]
    assign stop_tx = cmd_stop & (state_q == auto_ack_pkg::ST_TX_ON); // [RULE7]
    assign stop_rx = cmd_stop & (state_q == auto_ack_pkg::ST_RX_ON); // [RULE8]
    assign start_auto = auto_reply & timer_en & pending_q & (timer_q == 16'h0000)
                        & (state_q == auto_ack_pkg::ST_TX_ON); // [RULE18]
    assign start_send = pending_q & (state_q == auto_ack_pkg::ST_TX_ON) & ~cmd_stop
                        & (cmd_send | start_auto); // [RULE6]

    // Power-off and stop outrank a reception in the same cycle,
    // so a halted receiver never turns into a transmitter.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= auto_ack_pkg::ST_OFF;
        end else begin
            unique case (state_q)
                auto_ack_pkg::ST_OFF: begin
                    if (radio_i.goto_rx) begin
                        state_q <= auto_ack_pkg::ST_RX_ON;
                    end
                end
                auto_ack_pkg::ST_RX_ON: begin
                    if (radio_i.goto_off | stop_rx) begin
                        state_q <= auto_ack_pkg::ST_OFF; // [RULE8]
                    end else if (capture) begin
                        state_q <= auto_ack_pkg::ST_TX_ON; // [RULE4]
                    end
                end
                auto_ack_pkg::ST_TX_ON: begin
                    if (radio_i.goto_off) begin
                        state_q <= auto_ack_pkg::ST_OFF;
                    end else if (start_send) begin
                        state_q <= auto_ack_pkg::ST_SENDING;
                    end else if (tx_then_rx | radio_i.goto_rx) begin
                        state_q <= auto_ack_pkg::ST_RX_ON; // [RULE5]
                    end
                end
                auto_ack_pkg::ST_SENDING: begin
                    // Commands and events are ignored until the last bit is out.
                    if (last_beat) begin
                        state_q <= auto_ack_pkg::ST_TX_ON;
                    end
                end
            endcase
        end
    end

    // Pending reply and its sequence number.
    // Power-off drops the reply unless a reception captures one in the same cycle; that one stays pending.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pending_q <= 1'b0;
            seq_q <= 8'h00;
        end else if (capture) begin
            pending_q <= 1'b1;
            seq_q <= radio_i.rx_seq; // [RULE3]
        end else if (stop_tx | last_beat | radio_i.goto_off) begin
            pending_q <= 1'b0; // [RULE7]
        end
    end

    // Reply timer counts packet-engine ticks from the moment the reply is prepared.
    // A zero count with the timer enabled sends at once.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_q <= 16'h0000;
        end else if (capture) begin
            timer_q <= {timer_high_q, timer_low_q};
        end else if (radio_i.timer_tick & (timer_q != 16'h0000)) begin
            timer_q <= timer_q - 16'h0001; // [RULE18]
        end
    end

    // Serialiser: header bits LSB first, FCS computed on the fly and sent after.
    // The FCS register is shifted out itself; no second store.
    assign beat = (state_q == auto_ack_pkg::ST_SENDING) & ack_ready_i;
    assign last_beat = beat & (count_q == auto_ack_pkg::FRAME_BITS - 6'h1);
    assign in_header = (count_q < auto_ack_pkg::HDR_BITS);
    assign fcs_fb = shift_q[0] ^ fcs_q[0];
    assign fcs_shift = {1'b0, fcs_q[15:1]};
    assign ack_valid_o = (state_q == auto_ack_pkg::ST_SENDING);
    assign ack_bit_o = in_header ? shift_q[0] : fcs_q[0]; // [RULE1]
    assign ack_sent_o = sent_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_q <= 24'h00_0000;
            fcs_q <= auto_ack_pkg::FCS_INIT;
            count_q <= 6'h0;
        end else if (start_send) begin
            shift_q <= {seq_q, frame_high_q, frame_low_q}; // [RULE1] [RULE3]
            fcs_q <= auto_ack_pkg::FCS_INIT;
            count_q <= 6'h0;
        end else if (beat) begin
            count_q <= count_q + 6'h1;
            if (in_header) begin
                shift_q <= {1'b0, shift_q[23:1]};
                fcs_q <= fcs_fb ? (fcs_shift ^ auto_ack_pkg::FCS_POLY_REFL) : fcs_shift; // [RULE3]
            end else begin
                fcs_q <= fcs_shift;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sent_q <= 1'b0;
        end else begin
            sent_q <= last_beat;
        end
    end

    // Reply frame filter; address match plays no part in the verdict.
    // Verdicts are one-cycle pulses.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            await_first_q <= 1'b0;
        end else if (tx_then_rx) begin
            await_first_q <= 1'b1; // set wins over a same-cycle reception
        end else if (radio_i.rx_done) begin
            await_first_q <= 1'b0; // [RULE11]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            verdict_q <= '0;
        end else begin
            verdict_q <= '0;
            if (radio_i.rx_done & radio_i.rx_is_ack) begin // [RULE14]
                if (!cancel) begin
                    verdict_q.keep <= 1'b1; // [RULE13]
                end else if (auto_rx & await_first_q) begin
                    verdict_q.keep <= 1'b1; // [RULE11]
                end else begin
                    verdict_q.drop <= 1'b1; // [RULE12]
                end
            end
        end
    end

    // State and verdict leave straight from their flops.
    assign verdict_o = verdict_q;
    assign radio_state_o = state_q;

endmodule : auto_ack_control

/* dv/auto_ack_assertions.sv */
// Port checks for the automatic acknowledgement controller.
// Assumes a bind onto auto_ack_control; the control register is shadowed from bus writes.
`timescale 1ns/10ps

module auto_ack_assertions (
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [9:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // Radio side
    input wire auto_ack_pkg::radio_in_t radio_i,
    input wire logic ack_bit_o,
    input wire logic ack_valid_o,
    input wire logic ack_ready_i,
    input wire logic ack_sent_o,
    input wire auto_ack_pkg::radio_state_t radio_state_o,
    input wire auto_ack_pkg::ack_verdict_t verdict_o
);
    logic [7:0] ctrl_q;
    logic [5:0] beats_q;
    logic hit;
    logic rx_ack;

    assign hit = cyc_i & stb_i & ack_o & (adr_i[9:2] == auto_ack_pkg::IDX_AUTO_CTRL);
    assign rx_ack = radio_i.rx_done & radio_i.rx_is_ack;

    // The shadow updates on the same edge as the register, so antecedents see equal values.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= 8'h00;
        end else if (hit && we_i && sel_i[0]) begin
            ctrl_q <= dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || ack_sent_o) begin
            beats_q <= 6'd0;
        end else if (ack_valid_o && ack_ready_i) begin
            beats_q <= beats_q + 6'd1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_AUTO_REPLY: assert property (radio_state_o == auto_ack_pkg::ST_RX_ON && ctrl_q[4]
        && radio_i.rx_done && radio_i.rx_ack_req && !radio_i.rx_is_ack
        |=> radio_state_o == auto_ack_pkg::ST_TX_ON) else $error("no transmit-on after request");
    AST_AUTO_RX: assert property (radio_state_o == auto_ack_pkg::ST_TX_ON && ctrl_q[6]
        && radio_i.tx_done && radio_i.tx_ack_req
        |=> radio_state_o == auto_ack_pkg::ST_RX_ON) else $error("no receive-on after send");
    AST_STOP_TX: assert property (hit && we_i && sel_i[0] && dat_i[0]
        && radio_state_o == auto_ack_pkg::ST_TX_ON
        |=> (radio_state_o == auto_ack_pkg::ST_TX_ON && !ack_valid_o)[*3])
        else $error("stop in transmit mode misbehaved");
    AST_STOP_RX: assert property (hit && we_i && sel_i[0] && dat_i[0]
        && radio_state_o == auto_ack_pkg::ST_RX_ON
        |=> radio_state_o == auto_ack_pkg::ST_OFF) else $error("stop in receive mode misbehaved");
    AST_CMD_READ: assert property (hit && !we_i |-> dat_o[1:0] == 2'h0)
        else $error("command bits read back as set");
    AST_FORTY: assert property (ack_sent_o |-> beats_q == 6'd40 && !ack_valid_o)
        else $error("reply frame length wrong");
    AST_KEEP_ALL: assert property (rx_ack && !ctrl_q[7] |=> verdict_o == 2'h2)
        else $error("reply frame not kept");
    AST_DROP_ALL: assert property (rx_ack && ctrl_q[7] && !ctrl_q[6]
        |=> $past(rx_ack) && verdict_o == 2'h1) else $error("reply frame not dropped");
endmodule : auto_ack_assertions

bind auto_ack_control auto_ack_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .radio_i(radio_i), .ack_bit_o(ack_bit_o), .ack_valid_o(ack_valid_o),
    .ack_ready_i(ack_ready_i), .ack_sent_o(ack_sent_o), .radio_state_o(radio_state_o),
    .verdict_o(verdict_o));

/* dv/radio_node.sv */
// Far-side sink of reply bits: takes them by valid/ready and keeps the last frame.
// Assumes the controller's clock; ready changes only just after a rising edge.
`timescale 1ns/10ps

module radio_node (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pace and captured frame
    input wire logic slow_i,
    output logic [39:0] frame_o,
    // Reply bit stream
    input wire logic bit_i,
    input wire logic valid_i,
    output logic ready_o
);
    logic [5:0] n_q;
    logic [1:0] pace_q;

    // A slow sink takes one bit in four, so the sender has to hold each bit meanwhile.
    always_ff @(posedge clk_i) begin
        pace_q <= rst_i ? 2'h0 : pace_q + 2'h1;
        ready_o <= !rst_i && (!slow_i || pace_q == 2'h3);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !valid_i) begin
            n_q <= 6'd0;
        end else if (ready_o && n_q < 6'd40) begin
            frame_o[n_q] <= bit_i;
            n_q <= n_q + 6'd1;
        end
    end
endmodule : radio_node

/* dv/auto_ack_control_tb_top.sv */
// Self-checking bench of the automatic acknowledgement controller.
// Assumes the design package and the radio_node sink; one 50 MHz clock.
`timescale 1ns/10ps

module auto_ack_control_tb_top;
    logic clk_i;
    logic rst_i;
    logic cyc_i;
    logic stb_i;
    logic we_i;
    logic [9:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i;
    logic [31:0] dat_o;
    logic ack_o;
    auto_ack_pkg::radio_in_t radio_i;
    logic ack_bit_o;
    logic ack_valid_o;
    logic ack_ready_i;
    logic ack_sent_o;
    auto_ack_pkg::radio_state_t radio_state_o;
    auto_ack_pkg::ack_verdict_t verdict_o;
    logic slow;
    logic [39:0] frame;
    logic [31:0] rnd;
    logic [31:0] rd;
    logic [15:0] fc;
    int mismatches;
    int compares;

    localparam logic [7:0] AUTO = auto_ack_pkg::IDX_AUTO_CTRL;
    localparam logic [15:0] EV_RX_ON = 16'h0004;
    localparam logic [15:0] EV_TX_REQ = 16'h0018;
    localparam logic [15:0] EV_TICK = 16'h0001;
    localparam logic [15:0] EV_ACK_IN = 16'hA000;

    auto_ack_control DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .radio_i(radio_i), .ack_bit_o(ack_bit_o), .ack_valid_o(ack_valid_o),
        .ack_ready_i(ack_ready_i), .ack_sent_o(ack_sent_o), .radio_state_o(radio_state_o),
        .verdict_o(verdict_o));
    radio_node u_node (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .frame_o(frame),
        .bit_i(ack_bit_o), .valid_i(ack_valid_o), .ready_o(ack_ready_i));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    // Wire order: control field, sequence, then the reflected CRC, each LSB first.
    function automatic logic [39:0] reply(input logic [15:0] f, input logic [7:0] s);
        logic [23:0] h;
        logic [15:0] c;
        h = {s, f};
        c = 16'h0000;
        for (int i = 0; i < 24; i++) begin
            c = (c[0] ^ h[i]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
        end
        return {c, h};
    endfunction : reply

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'h0};
        dat_i <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n == 20) begin
            mismatches++;
            wrap_up();
        end
        @(negedge clk_i);
    endtask : wb

    task automatic ev(input logic [15:0] v);
        @(posedge clk_i);
        radio_i <= auto_ack_pkg::radio_in_t'(v);
        @(posedge clk_i);
        radio_i <= '0;
        @(negedge clk_i);
    endtask : ev

    task automatic take(input logic [39:0] exp);
        int n;
        n = 0;
        while (ack_sent_o !== 1'b1 && n < 400) begin
            @(negedge clk_i);
            n++;
        end
        if (n == 400) begin
            mismatches++;
            wrap_up();
        end
        chk(frame, exp);
        chk(radio_state_o, auto_ack_pkg::ST_TX_ON);
    endtask : take

    task automatic rx_req();
        rnd = xorshift(rnd);
        ev({3'h6, rnd[7:0], 5'h00});
        chk(radio_state_o, auto_ack_pkg::ST_TX_ON);
    endtask : rx_req

    initial begin
        rst_i = 1'b1;
        {cyc_i, stb_i, we_i, slow} = 4'h0;
        adr_i = 10'h000;
        sel_i = 4'h1;
        dat_i = 32'h0000_0000;
        radio_i = '0;
        rnd = 32'h0000_caf1;
        mismatches = 0;
        compares = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        sel_i <= 4'he;
        wb(1, 8'h53, 8'hff);
        @(posedge clk_i);
        sel_i <= 4'h1;
        wb(0, 8'h53, 8'h00);
        chk(rd, 32'h0000_0002);
        wb(0, 8'h54, 8'h00);
        chk(rd, 32'h0000_0000);
        wb(0, AUTO, 8'h00);
        chk(rd, 32'h0000_0000);
        wb(1, 8'h56, 8'hff);
        wb(0, 8'h56, 8'h00);
        chk(rd, 32'h0000_0000);
        wb(1, AUTO, 8'h10);
        for (int k = 0; k < 6; k++) begin
            rnd = xorshift(rnd);
            fc = rnd[15:0];
            slow = rnd[16];
            wb(1, 8'h53, fc[7:0]);
            wb(1, 8'h54, fc[15:8]);
            wb(0, 8'h54, 8'h00);
            chk(rd, {24'h00_0000, fc[15:8]});
            ev(EV_RX_ON);
            rx_req();
            wb(1, AUTO, 8'h12);
            take(reply(fc, rnd[7:0]));
            wb(0, AUTO, 8'h00);
            chk(rd, 32'h0000_0010);
        end
        for (int k = 0; k < 2; k++) begin
            ev(EV_RX_ON);
            rx_req();
            wb(0, 8'h70, 8'h00);
            chk(rd, 32'h0000_0006);
            wb(1, AUTO, k ? 8'h13 : 8'h11);
            wb(1, AUTO, 8'h12);
            repeat (3) @(negedge clk_i);
            chk({ack_valid_o, radio_state_o}, 3'h2);
        end
        ev(EV_RX_ON);
        wb(1, AUTO, 8'h11);
        chk(radio_state_o, auto_ack_pkg::ST_OFF);
        wb(1, AUTO, 8'hd0);
        ev(EV_RX_ON);
        rx_req();
        ev(EV_TX_REQ);
        chk(radio_state_o, auto_ack_pkg::ST_RX_ON);
        ev(EV_ACK_IN);
        chk(verdict_o, 2'h2);
        ev(EV_ACK_IN);
        chk(verdict_o, 2'h1);
        for (int k = 0; k < 3; k++) begin
            wb(1, AUTO, k == 0 ? 8'h80 : {1'b0, k[0], 6'h00});
            ev(EV_ACK_IN);
            chk(verdict_o, k == 0 ? 2'h1 : 2'h2);
        end
        wb(1, 8'h50, 8'h03);
        wb(1, 8'h51, 8'h00);
        wb(1, 8'h52, 8'h01);
        wb(1, AUTO, 8'h10);
        rx_req();
        ev(EV_TICK);
        ev(EV_TICK);
        chk(ack_valid_o, 1'b0);
        ev(EV_TICK);
        take(reply(fc, rnd[7:0]));
        wrap_up();
    end
endmodule : auto_ack_control_tb_top
